// ### cfgw_pkg.sv
// package for the configuration and wake-up sequencer
package cfgw_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000;
   localparam int INIT_CLEAR_NS = 2000;
   localparam int INIT_CLEAR_CYCLES =
      (INIT_CLEAR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 16;

   // ----------------------------------------------------------------
   // configuration port codes
   // ----------------------------------------------------------------
   localparam logic [1:0] PORT_JTAG = 2'h0;
   localparam logic [1:0] PORT_SPI = 2'h1;
   localparam logic [1:0] PORT_I2C = 2'h2;
   localparam logic [1:0] PORT_WB = 2'h3;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CFGW_INIT,
      CFGW_CONFIG,
      CFGW_WAKE,
      CFGW_USER,
      CFGW_ERROR,
      CFGW_PROG
   } cfgw_state_t;

   typedef enum logic [2:0] {
      CFGW_WK_IDLE,
      CFGW_WK_PH1,
      CFGW_WK_PH2,
      CFGW_WK_PH3,
      CFGW_WK_DONE
   } cfgw_wake_t;

   // memory access request from a configuration port
   typedef struct packed {
      logic [1:0] port;
      logic nv_space;
      logic write;
      logic transparent;
   } cfgw_acc_t;

   // global control strobes driven into the fabric
   typedef struct packed {
      logic global_output_en;
      logic global_set_reset;
      logic global_ram_write_block;
   } cfgw_glob_t;

endpackage

// ### cfgw_sequencer.sv
// configuration state, wake-up sequencer and port access control
`timescale 1ns/10ps

// Summary of operation
// - init pin rising edge enters configuration
// - configuration fetches from internal or spi flash
// - no valid image keeps configuration state
// - init pin high ok, low on error
// - completion bit starts three phase wake-up
// - phase one releases global output enable
// - set/reset blocks inputs until released
// - phase two releases set/reset and write-block
// - set/reset forces flagged flip-flops
// - write-block overrides all ram writes
// - last phase releases open-drain completion pin
// - enabled completion pin low stalls finish
// - disabled completion pin never stalls
// - user mode until reprogram, reload, offline start, power
// - trigger drives init and completion low
// - reload accepted from any active port
// - jtag full access, spi/i2c no sram read
// - wishbone nv access only when transparent
// - jtag offline or transparent both spaces
// - offline programming halts user logic
// - background keeps user logic, reload loads
// - init waits clear time, reprogram, pin
module cfgw_sequencer #(
   parameter int INIT_CYCLES = cfgw_pkg::INIT_CLEAR_CYCLES
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire logic i_link_clk,
   // init status pin (open drain)
   input wire logic i_init_status_n,
   output logic o_init_status_n,
   output logic o_init_status_oe,
   // completion pin (open drain)
   input wire logic i_done,
   output logic o_done,
   output logic o_done_oe,
   input wire logic i_done_pin_en,
   // reprogram pin
   input wire logic i_reprogram_request_n,
   // image fetch side; stream inputs in link clock domain, image-ok inputs and fetch outputs on the reference clock
   input wire logic i_img_valid,
   input wire logic i_img_last,
   input wire logic i_img_error,
   input wire logic i_int_image_ok,
   input wire logic i_ext_image_ok,
   output logic o_fetch_en,
   output logic o_fetch_ext,
   // configuration port commands
   input wire logic i_reload,
   input wire logic i_offline_start,
   input wire logic i_offline_end,
   input wire logic i_background_flash_op,
   input wire cfgw_pkg::cfgw_acc_t i_acc,
   output logic o_acc_grant,
   // fabric controls
   output cfgw_pkg::cfgw_glob_t o_glob,
   output logic o_user_mode,
   output logic o_error,
   output cfgw_pkg::cfgw_state_t o_state
);
   import cfgw_pkg::*;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic init_s1, init_s2, init_prev;
   logic done_s1, done_s2;
   logic prog_s1, prog_s2;
   logic iok_s1, iok_s2, eok_s1, eok_s2;

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_nrst)
      begin
         init_s1 <= 1'b0;
         init_s2 <= 1'b0;
         init_prev <= 1'b0;
         done_s1 <= 1'b0;
         done_s2 <= 1'b0;
         prog_s1 <= 1'b1;
         prog_s2 <= 1'b1;
         iok_s1 <= 1'b0;
         iok_s2 <= 1'b0;
         eok_s1 <= 1'b0;
         eok_s2 <= 1'b0;
      end
      else
      begin
         init_s1 <= i_init_status_n;
         init_s2 <= init_s1;
         init_prev <= init_s2;
         done_s1 <= i_done;
         done_s2 <= done_s1;
         prog_s1 <= i_reprogram_request_n;
         prog_s2 <= prog_s1;
         iok_s1 <= i_int_image_ok;
         iok_s2 <= iok_s1;
         eok_s1 <= i_ext_image_ok;
         eok_s2 <= eok_s1;
      end
   end

   // ----------------------------------------------------------------
   // link domain: image stream receiver
   // ----------------------------------------------------------------
   // events cross as toggles; the link clock may stop after the last word
   logic lk_fetch_s1, lk_fetch_s2, fetch_q;
   logic lk_done_tgl, lk_err_tgl;

   always_ff @(posedge i_link_clk)
   begin
      if (!i_nrst)
      begin
         lk_fetch_s1 <= 1'b0;
         lk_fetch_s2 <= 1'b0;
         lk_done_tgl <= 1'b0;
         lk_err_tgl <= 1'b0;
      end
      else
      begin
         lk_fetch_s1 <= fetch_q;
         lk_fetch_s2 <= lk_fetch_s1;
         if (lk_fetch_s2 && i_img_valid && i_img_error)
            lk_err_tgl <= ~lk_err_tgl;
         else if (lk_fetch_s2 && i_img_valid && i_img_last)
            lk_done_tgl <= ~lk_done_tgl;
      end
   end

   logic dt_s1, dt_s2, dt_s3, et_s1, et_s2, et_s3;

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_nrst)
      begin
         dt_s1 <= 1'b0;
         dt_s2 <= 1'b0;
         dt_s3 <= 1'b0;
         et_s1 <= 1'b0;
         et_s2 <= 1'b0;
         et_s3 <= 1'b0;
      end
      else
      begin
         dt_s1 <= lk_done_tgl;
         dt_s2 <= dt_s1;
         dt_s3 <= dt_s2;
         et_s1 <= lk_err_tgl;
         et_s2 <= et_s1;
         et_s3 <= et_s2;
      end
   end

   wire cfg_done_evt = dt_s2 ^ dt_s3;
   wire cfg_err_evt = et_s2 ^ et_s3;

   // ----------------------------------------------------------------
   // main state machine
   // ----------------------------------------------------------------
   cfgw_state_t state, next_state;
   cfgw_wake_t wake, next_wake;
   logic [CNT_W-1:0] clr_cnt;
   logic done_bit;

   wire init_rise = init_s2 && !init_prev;
   wire reprogram = !prog_s2;
   wire any_image = iok_s2 || eok_s2;
   // reload accepted only in user mode, from whichever port sent it
   wire trigger = (state == CFGW_USER) && (reprogram || i_reload);
   wire clear_done = (clr_cnt >= INIT_CYCLES[CNT_W-1:0]);
   wire wake_fin = (wake == CFGW_WK_DONE);

   always_comb
   begin
      next_state = state;
      case (state)
         CFGW_INIT:
            // pin only rises once clear time, reprogram and masters all agree
            if (init_rise && clear_done && !reprogram)
               next_state = CFGW_CONFIG;
         CFGW_CONFIG:
            if (cfg_err_evt)
               next_state = CFGW_ERROR;
            else if (done_bit && any_image)
               next_state = CFGW_WAKE;
         CFGW_WAKE:
            if (wake_fin)
               next_state = CFGW_USER;
         CFGW_USER:
            if (trigger)
               next_state = CFGW_INIT;
            else if (i_offline_start)
               next_state = CFGW_PROG;
         CFGW_PROG:
            if (i_offline_end)
               next_state = CFGW_INIT;
         CFGW_ERROR:
            if (reprogram)
               next_state = CFGW_INIT;
         default:
            next_state = CFGW_INIT;
      endcase
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_nrst)
         state <= CFGW_INIT;
      else
         state <= next_state;
   end

   // registered copy for the link side: a decoded state can glitch
   always_ff @(posedge i_ref_clk)
      fetch_q <= i_nrst && (next_state == CFGW_CONFIG);

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_nrst || state != CFGW_INIT)
         clr_cnt <= '0;
      else if (!clear_done)
         clr_cnt <= clr_cnt + 1'b1;
   end

   // internal completion bit; without a valid image it never matters
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_nrst || state != CFGW_CONFIG)
         done_bit <= 1'b0;
      else if (cfg_done_evt && any_image)
         done_bit <= 1'b1;
   end

   // ----------------------------------------------------------------
   // wake-up sequencer, one phase per cycle at most
   // ----------------------------------------------------------------
   always_comb
   begin
      next_wake = wake;
      case (wake)
         CFGW_WK_IDLE:
            if (state == CFGW_WAKE)
               next_wake = CFGW_WK_PH1;
         CFGW_WK_PH1:
            next_wake = CFGW_WK_PH2;
         CFGW_WK_PH2:
            next_wake = CFGW_WK_PH3;
         CFGW_WK_PH3:
            if (!i_done_pin_en || done_s2)
               next_wake = CFGW_WK_DONE;
         CFGW_WK_DONE:
            next_wake = CFGW_WK_DONE;
         default:
            next_wake = CFGW_WK_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_nrst || state == CFGW_INIT || state == CFGW_CONFIG)
         wake <= CFGW_WK_IDLE;
      else
         wake <= next_wake;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // strobes follow the phases only while waking or in user mode
   wire user_on = (state == CFGW_USER);
   wire awake = (state == CFGW_WAKE) || user_on;
   wire goe_on = (wake != CFGW_WK_IDLE) && awake;
   wire gsr_off = ((wake == CFGW_WK_PH2) || (wake == CFGW_WK_PH3) || wake_fin) && awake;

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_nrst)
      begin
         o_glob <= '{global_output_en: 1'b0, global_set_reset: 1'b1,
                     global_ram_write_block: 1'b1};
         o_user_mode <= 1'b0;
         o_error <= 1'b0;
      end
      else
      begin
         o_glob.global_output_en <= goe_on;
         // held set/reset also blocks always-active inputs from flops
         o_glob.global_set_reset <= !gsr_off;
         o_glob.global_ram_write_block <= !gsr_off;
         o_user_mode <= user_on;
         o_error <= (state == CFGW_ERROR);
      end
   end

   // open drain: drive low only. init low in error, and in init until clear time or while reprogram is held, else released
   assign o_init_status_n = 1'b0;
   assign o_init_status_oe = (state == CFGW_INIT && (!clear_done || reprogram)) ||
                             (state == CFGW_ERROR);
   assign o_done = 1'b0;
   // completion pin held low until the last phase releases it
   assign o_done_oe = !awake || ((wake != CFGW_WK_PH3) && !wake_fin);
   assign o_fetch_en = (state == CFGW_CONFIG);
   assign o_fetch_ext = !iok_s2 && eok_s2;
   assign o_state = state;

   // ----------------------------------------------------------------
   // memory space access control
   // ----------------------------------------------------------------
   // background flash ops are granted only while user mode is kept
   wire acc_jtag = (i_acc.port == PORT_JTAG);
   wire acc_spi_i2c = (i_acc.port == PORT_SPI) || (i_acc.port == PORT_I2C);
   wire acc_wb = (i_acc.port == PORT_WB) && i_acc.nv_space && i_acc.transparent;
   wire acc_bg_ok = !i_background_flash_op || user_on;
   assign o_acc_grant = acc_bg_ok && (acc_jtag ||
                        (acc_spi_i2c && (i_acc.nv_space || i_acc.write)) || acc_wb);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_init_to_cfg;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      (state == CFGW_CONFIG) && $past(state) == CFGW_INIT |-> $past(init_rise);
   endproperty
   a_init_to_cfg: assert property (p_init_to_cfg) else $error("config without init rise");

   property p_no_image;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      (state == CFGW_CONFIG) && !any_image |=> state != CFGW_WAKE;
   endproperty
   a_no_image: assert property (p_no_image) else $error("left config with no image");

   property p_err_pin;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      state == CFGW_ERROR |-> o_init_status_oe && !o_user_mode;
   endproperty
   a_err_pin: assert property (p_err_pin) else $error("error not on init pin");

   property p_phase_order;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      wake == CFGW_WK_PH1 |=> wake == CFGW_WK_PH2 ##1 wake == CFGW_WK_PH3;
   endproperty
   a_phase_order: assert property (p_phase_order) else $error("wake phases out of order");

   property p_goe_first;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      $rose(o_glob.global_output_en) |-> o_glob.global_set_reset ##1 !o_glob.global_set_reset;
   endproperty
   a_goe_first: assert property (p_goe_first) else $error("output enable not first");

   property p_gsr_gw;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      o_user_mode |-> !o_glob.global_set_reset && !o_glob.global_ram_write_block;
   endproperty
   a_gsr_gw: assert property (p_gsr_gw) else $error("strobes held in user mode");

   property p_done_stall;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      wake == CFGW_WK_PH3 && i_done_pin_en && !done_s2 |=> wake == CFGW_WK_PH3;
   endproperty
   a_done_stall: assert property (p_done_stall) else $error("finished with pin low");

   property p_done_free;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      wake == CFGW_WK_PH3 && !i_done_pin_en |=> wake_fin;
   endproperty
   a_done_free: assert property (p_done_free) else $error("stalled with pin disabled");

   property p_trigger;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      trigger |=> state == CFGW_INIT && o_init_status_oe && o_done_oe;
   endproperty
   a_trigger: assert property (p_trigger) else $error("trigger did not reinit");

   property p_sram_read;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      o_acc_grant && !i_acc.nv_space && !i_acc.write |-> acc_jtag;
   endproperty
   a_sram_read: assert property (p_sram_read) else $error("sram read by non-jtag port");

   c_wake: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
      $rose(o_user_mode));
   c_stall: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
      wake == CFGW_WK_PH3 && i_done_pin_en && !done_s2);
   c_err: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
      state == CFGW_ERROR);
   c_reload: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
      trigger && i_reload);

endmodule // cfgw_sequencer

// ### cfgw_img_src.sv
// behavioural image source standing on the link side of the sequencer
`timescale 1ns/10ps
module cfgw_img_src (
   // link clock and bench controls
   input wire logic i_link_clk,
   input wire logic i_fetch_en,
   input wire logic i_send,
   input wire logic i_bad,
   input wire logic i_slow,
   // image stream
   output logic o_img_valid = 1'b0,
   output logic o_img_last = 1'b0,
   output logic o_img_error = 1'b0
);
   // ------------------------------------------------------------------
   // stream of six words
   // ------------------------------------------------------------------
   logic [3:0] cnt = 4'h0;
   logic ph = 1'b0;
   wire run = i_fetch_en && i_send;
   // three idle edges first, so the receiver's synchroniser sees the enable
   wire word = run && cnt >= 4'h3 && cnt <= 4'h8 && !(i_slow && ph);

   // the link clock stops with the request, so the frame count clears on its fall
   always @(posedge i_link_clk or negedge run)
   begin
      if (!run)
         cnt <= 4'h0;
      else if (cnt < 4'h3 || word)
         cnt <= cnt + 4'h1;
   end

   always @(posedge i_link_clk)
   begin
      ph <= ~ph;
      o_img_valid <= word;
      // idle qualifiers toggle so a stale level never looks like a word
      o_img_last <= word ? cnt == 4'h8 : ~o_img_last;
      o_img_error <= word ? i_bad && cnt == 4'h8 : ~o_img_error;
   end
endmodule // cfgw_img_src

// ### cfgw_sequencer_test.sv
// self-checking bench for the configuration and wake-up sequencer
`timescale 1ns/10ps
module cfgw_sequencer_test;
   import cfgw_pkg::*;
   logic i_ref_clk = 0, i_link_clk = 0, i_nrst = 0, in_rst = 1, send = 0, bad = 0, slow = 0;
   logic ext_init_low = 1, ext_done_low = 0, i_done_pin_en = 0, i_reprogram_request_n = 1;
   logic i_int_image_ok = 0, i_ext_image_ok = 0, i_reload = 0, i_offline_start = 0;
   logic i_offline_end = 0, i_background_flash_op = 0;
   logic i_img_valid, i_img_last, i_img_error, o_init_status_n, o_init_status_oe, o_done;
   logic o_done_oe, o_fetch_en, o_fetch_ext, o_acc_grant, o_user_mode, o_error;
   cfgw_acc_t i_acc = '0;
   cfgw_glob_t o_glob;
   cfgw_state_t o_state;
   int miscompares = 0, cmp_count = 0, cyc = 0;
   // open-drain pins with pull-ups, pulled low by either party
   wire init_pin = (o_init_status_oe ? o_init_status_n : 1'b1) & ~ext_init_low;
   wire done_pin = (o_done_oe ? o_done : 1'b1) & ~ext_done_low;
   // link clock stands still outside reset and frames
   wire lk_en = in_rst | (o_fetch_en & send);

   always #2 i_ref_clk = ~i_ref_clk;
   initial #1.1 forever #3 i_link_clk = lk_en ? ~i_link_clk : 1'b0;

   cfgw_sequencer #(.INIT_CYCLES(8)) dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
      .i_link_clk(i_link_clk), .i_init_status_n(init_pin), .o_init_status_n(o_init_status_n),
      .o_init_status_oe(o_init_status_oe), .i_done(done_pin), .o_done(o_done),
      .o_done_oe(o_done_oe), .i_done_pin_en(i_done_pin_en),
      .i_reprogram_request_n(i_reprogram_request_n), .i_img_valid(i_img_valid),
      .i_img_last(i_img_last), .i_img_error(i_img_error), .i_int_image_ok(i_int_image_ok),
      .i_ext_image_ok(i_ext_image_ok), .o_fetch_en(o_fetch_en), .o_fetch_ext(o_fetch_ext),
      .i_reload(i_reload), .i_offline_start(i_offline_start), .i_offline_end(i_offline_end),
      .i_background_flash_op(i_background_flash_op), .i_acc(i_acc), .o_acc_grant(o_acc_grant),
      .o_glob(o_glob), .o_user_mode(o_user_mode), .o_error(o_error), .o_state(o_state));

   cfgw_img_src src (.i_link_clk(i_link_clk), .i_fetch_en(o_fetch_en), .i_send(send),
      .i_bad(bad), .i_slow(slow), .o_img_valid(i_img_valid), .o_img_last(i_img_last),
      .o_img_error(i_img_error));

   // ------------------------------------------------------------------
   // checking and closing
   // ------------------------------------------------------------------
   task results;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task chk(input string nm, input logic e, input logic g);
      cmp_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("unexpected %s: expected %b seen %b", nm, e, g);
      end
   endtask

   task wait_st(input cfgw_state_t e, input int n);
      int k;
      k = 0;
      @(negedge i_ref_clk);
      while (o_state !== e && k < n)
      begin
         @(negedge i_ref_clk);
         k++;
      end
      cmp_count++;
      if (o_state !== e)
      begin
         miscompares++;
         $display("unexpected state: expected %0d seen %0d", e, o_state);
      end
   endtask

   // hang guard: a full run needs well under 3000 cycles
   always @(posedge i_ref_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         results;
      end
   end

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task boot(input logic b, input logic intok, input logic en, input logic hold, input logic sl);
      int k;
      @(posedge i_ref_clk);
      {bad, i_int_image_ok, i_ext_image_ok, slow} <= {b, intok, ~intok, sl};
      {i_done_pin_en, ext_done_low, send} <= {en, hold, 1'b1};
      wait_st(CFGW_CONFIG, 40);
      chk("fetch_en", 1, o_fetch_en);
      chk("fetch_ext", ~intok, o_fetch_ext);
      chk("init_oe", 0, o_init_status_oe);
      if (b)
      begin
         wait_st(CFGW_ERROR, 80);
         @(negedge i_ref_clk);
         chk("error", 1, o_error);
         chk("init_oe", 1, o_init_status_oe);
      end
      else
      begin
         k = 0;
         while (o_glob.global_output_en !== 1'b1 && k < 80)
         begin
            @(negedge i_ref_clk);
            k++;
         end
         chk("goe", 1, o_glob.global_output_en);
         chk("gsr", 1, o_glob.global_set_reset);
         chk("wblk", 1, o_glob.global_ram_write_block);
         @(negedge i_ref_clk);
         chk("gsr", 0, o_glob.global_set_reset);
         chk("wblk", 0, o_glob.global_ram_write_block);
         chk("done_oe", 0, o_done_oe);
         if (hold && en)
         begin
            repeat (10) @(negedge i_ref_clk);
            chk("user", 0, o_user_mode);
            @(posedge i_ref_clk);
            ext_done_low <= 0;
         end
         k = 0;
         while (o_user_mode !== 1'b1 && k < 8)
         begin
            @(negedge i_ref_clk);
            k++;
         end
         chk("user", 1, o_user_mode);
      end
      @(posedge i_ref_clk);
      {send, ext_done_low} <= 2'h0;
   endtask

   task trig(input logic prog);
      @(posedge i_ref_clk);
      if (prog)
         i_reprogram_request_n <= 0;
      else
         i_reload <= 1;
      @(posedge i_ref_clk);
      i_reload <= 0;
      wait_st(CFGW_INIT, 10);
      chk("init_oe", 1, o_init_status_oe);
      chk("done_oe", 1, o_done_oe);
      @(posedge i_ref_clk);
      i_reprogram_request_n <= 1;
   endtask

   task acc_tab;
      logic e;
      for (int k = 0; k < 32; k++)
      begin
         @(posedge i_ref_clk);
         i_acc <= cfgw_acc_t'(k[4:0]);
         @(negedge i_ref_clk);
         e = k[4:3] == 0 | (k[4:3] != 3 & (k[2] | k[1])) | (k[4:3] == 3 & k[2] & k[0]);
         chk("grant", e, o_acc_grant);
      end
   endtask

   task offline;
      @(posedge i_ref_clk);
      i_offline_start <= 1;
      @(posedge i_ref_clk);
      i_offline_start <= 0;
      wait_st(CFGW_PROG, 10);
      repeat (2) @(negedge i_ref_clk);
      chk("user", 0, o_user_mode);
      chk("goe", 0, o_glob.global_output_en);
      @(posedge i_ref_clk);
      i_background_flash_op <= 1;
      @(negedge i_ref_clk);
      chk("grant", 0, o_acc_grant);
      @(posedge i_ref_clk);
      {i_background_flash_op, i_offline_end} <= 2'h1;
      @(posedge i_ref_clk);
      i_offline_end <= 0;
      wait_st(CFGW_INIT, 10);
   endtask

   initial
   begin
      repeat (8) @(posedge i_ref_clk);
      i_nrst <= 1;
      in_rst <= 0;
      @(negedge i_ref_clk);
      chk("goe", 0, o_glob.global_output_en);
      chk("gsr", 1, o_glob.global_set_reset);
      chk("wblk", 1, o_glob.global_ram_write_block);
      chk("done_oe", 1, o_done_oe);
      repeat (30) @(negedge i_ref_clk);
      wait_st(CFGW_INIT, 0);
      @(posedge i_ref_clk);
      ext_init_low <= 0;
      boot(0, 1, 1, 1, 0);
      acc_tab;
      @(posedge i_ref_clk);
      {i_background_flash_op, i_acc} <= {1'b1, PORT_JTAG, 3'h6}; // host keeps its pll
      repeat (5) @(negedge i_ref_clk);
      chk("user", 1, o_user_mode);
      chk("grant", 1, o_acc_grant);
      @(posedge i_ref_clk);
      i_background_flash_op <= 0;
      trig(0);
      boot(0, 0, 0, 1, 1);
      trig(1);
      boot(0, 1, 0, 0, 0);
      offline;
      boot(1, 1, 0, 0, 1);
      trig(1);
      @(posedge i_ref_clk);
      {bad, i_int_image_ok, i_ext_image_ok, send} <= 4'h1;
      wait_st(CFGW_CONFIG, 40);
      @(posedge i_ref_clk);
      i_reload <= 1;
      @(posedge i_ref_clk);
      i_reload <= 0;
      repeat (40) @(negedge i_ref_clk);
      wait_st(CFGW_CONFIG, 0);
      results;
   end
endmodule // cfgw_sequencer_test
